// ### tps_clkgen.sv
// control logic of a three-pll clock generator with pin frequency select
// assumes clk is the reference; pins are asynchronous and synchronised here
// Overview of operation
// [RQ1] select bits zero and one are captured from the serial pins at start-up
// [RQ2] low shutdown pin tristates all outputs and by default powers the chip down
// [RQ3] optionally a low shutdown pin only tristates outputs, chip keeps running
// [RQ4] live select pin is index bit two, or the suspend input when configured
// [RQ5] each pll runs at reference times p over q, 11-bit p and 8-bit q; the plls here clip at one tick per cycle when p is not below q
// [RQ6] pll1 feeds the cross point and a /2 /3 /4 divider driving output e
// [RQ7] pll1 set by table or software; pll2 and pll3 by software only
// [RQ8] toggling the live select pin swaps pll1 setting and a/b divider choice
// [RQ9] three select bits index eight rows of pll1 p, q and divider choice
// [RQ10] outputs a and b share one choice between divider register 0 and 1
// [RQ11] divider changes from the live select pin take effect glitch free
// [RQ12] crystal drive strength is a programmable setting
// [RQ13] six-bit load capacitance field, 0.375 pF steps from 6 pF to 30 pF
// [RQ14] load capacitors may be bypassed for a driven reference input
// [RQ15] a buffered copy of the reference appears on the reference output
// [RQ16] output divider 1 to 127; zero powers it down and tristates output
// [RQ17] in suspend mode a low pin stops a programmable set of outputs and plls
// [RQ18] full shutdown only when shutdown enable is set, else outputs only tristate
// [RQ19] after capture, select bits zero and one stay fixed until next reset
`timescale 1ns/1ps
`include "tps_map.svh"

module tps_clkgen
  import tps_pkg::*;
(
  input  wire logic        clk,                 // reference clock, 100 MHz
  input  wire logic        rst,                 // async reset, active high
  input  wire logic        ce,                  // clock enable, freezes state
  input  wire logic [5:0]  addr,                // register word address
  input  wire logic [31:0] wdata,               // write data
  input  wire logic        wr,                  // write strobe
  input  wire logic        rd,                  // read strobe
  output logic      [31:0] rdata,               // read data, cycle after rd
  input  wire logic        serial_data_pin,     // select bit zero at start-up
  input  wire logic        serial_clock_pin,    // select bit one at start-up
  input  wire logic        live_select_bit_two, // index bit two or suspend
  input  wire logic        oe_shutdown_n,       // low: tristate / shutdown
  output logic             output_a,            // clock output a
  output logic             output_a_oe_n,       // low while output a drives
  output logic             output_b,            // clock output b
  output logic             output_b_oe_n,       // low while output b drives
  output logic             output_c,            // clock output c
  output logic             output_c_oe_n,       // low while output c drives
  output logic             output_d,            // clock output d
  output logic             output_d_oe_n,       // low while output d drives
  output logic             output_e,            // pll1 post-divided output
  output logic             output_e_oe_n,       // low while output e drives
  output logic             ref_out,             // buffered reference
  output logic             ref_out_oe_n,        // low while ref_out drives
  output logic             chip_powerdown,      // whole chip shut down
  output logic      [10:0] pll1_p,              // active pll1 feedback count
  output logic      [7:0]  pll1_q,              // active pll1 input divider
  output logic      [1:0]  xtal_drive,          // oscillator drive strength
  output logic      [5:0]  xtal_cap,            // load capacitance code
  output logic             xtal_bypass          // load capacitors bypassed
);

  logic [3:0]  sync1_ff, sync2_ff;
  logic        serial_data_pin_s, sclk_s, s2_s, oe_s;
  logic [31:0] ctrl_ff, route_ff, diva_ff, divb_ff, divcd_ff, susp_ff, pll2_ff, pll3_ff;
  logic [31:0] nxt_ctrl, nxt_route, nxt_diva, nxt_divb, nxt_divcd, nxt_susp, nxt_pll2, nxt_pll3;
  logic [24:0] tbl_ff [8];
  logic [24:0] nxt_tbl [8];
  logic [31:0] rdata_ff, nxt_rdata;
  tps_state_t  state_ff, nxt_state;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [1:0]  sel_lo_ff, nxt_sel_lo;
  logic [2:0]  idx, idx_ff;
  logic [24:0] row;
  tps_p_t      p1_ff;
  tps_q_t      q1_ff;
  logic        dsel_ff;
  logic        run, oe_low, pd, susp, pd_ff, ref_ff, ref_oen_ff;
  logic [5:0]  cap_ff;
  tps_p_t      pp [3];
  tps_q_t      pq [3];
  logic [2:0]  prun, ptick_ff;
  logic [7:0]  acc_ff [3];
  logic [3:0]  stick;
  tps_div_t    dv [5];
  tps_src_t    srcsel [5];
  logic [4:0]  o_off, clk_ff, oen_ff;
  tps_div_t    cur_ff [5];
  tps_div_t    dcnt_ff [5];

  // pins come from outside the clock domain
  // shutdown pin idles high; a low reset value would fake a shutdown after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 4'h8;
      sync2_ff <= 4'h8;
    end else if (ce) begin
      sync1_ff <= {oe_shutdown_n, live_select_bit_two, serial_clock_pin, serial_data_pin};
      sync2_ff <= sync1_ff;
    end
  end
  assign {oe_s, s2_s, sclk_s, serial_data_pin_s} = sync2_ff;

  // register file
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_route = route_ff;
    nxt_diva  = diva_ff;
    nxt_divb  = divb_ff;
    nxt_divcd = divcd_ff;
    nxt_susp  = susp_ff;
    nxt_pll2  = pll2_ff;
    nxt_pll3  = pll3_ff;
    nxt_tbl   = tbl_ff;
    nxt_rdata = 32'h0000_0000;
    if (wr) begin
      if (addr[5:3] == `TPS_A_TBL) begin
        nxt_tbl[addr[2:0]] = wdata[24:0]; // RQ7
      end else begin
        case (addr)
          `TPS_A_CTRL:  nxt_ctrl  = wdata;
          `TPS_A_ROUTE: nxt_route = wdata;
          `TPS_A_DIVA:  nxt_diva  = wdata;
          `TPS_A_DIVB:  nxt_divb  = wdata;
          `TPS_A_DIVCD: nxt_divcd = wdata;
          `TPS_A_SUSP:  nxt_susp  = wdata;
          `TPS_A_PLL2:  nxt_pll2  = wdata; // RQ7
          `TPS_A_PLL3:  nxt_pll3  = wdata; // RQ7
          default:      nxt_ctrl  = ctrl_ff;
        endcase
      end
    end
    if (rd) begin
      if (addr[5:3] == `TPS_A_TBL) begin
        nxt_rdata = {7'h00, tbl_ff[addr[2:0]]};
      end else begin
        case (addr)
          `TPS_A_CTRL:  nxt_rdata = ctrl_ff;
          `TPS_A_ROUTE: nxt_rdata = route_ff;
          `TPS_A_DIVA:  nxt_rdata = diva_ff;
          `TPS_A_DIVB:  nxt_rdata = divb_ff;
          `TPS_A_DIVCD: nxt_rdata = divcd_ff;
          `TPS_A_SUSP:  nxt_rdata = susp_ff;
          `TPS_A_PLL2:  nxt_rdata = pll2_ff;
          `TPS_A_PLL3:  nxt_rdata = pll3_ff;
          `TPS_A_STAT:  nxt_rdata = {22'h0, pd_ff, susp, oe_low, run, sel_lo_ff, dsel_ff, idx_ff};
          default:      nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff  <= `TPS_CTRL_RST;
      route_ff <= `TPS_ROUTE_RST;
      diva_ff  <= 32'h0000_0000;
      divb_ff  <= 32'h0000_0000;
      divcd_ff <= 32'h0000_0000;
      susp_ff  <= 32'h0000_0000;
      pll2_ff  <= 32'h0000_0000;
      pll3_ff  <= 32'h0000_0000;
      rdata_ff <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
        tbl_ff[i] <= 25'h000_0000;
      end
    end else if (ce) begin
      ctrl_ff  <= nxt_ctrl;
      route_ff <= nxt_route;
      diva_ff  <= nxt_diva;
      divb_ff  <= nxt_divb;
      divcd_ff <= nxt_divcd;
      susp_ff  <= nxt_susp;
      pll2_ff  <= nxt_pll2;
      pll3_ff  <= nxt_pll3;
      rdata_ff <= nxt_rdata;
      tbl_ff   <= nxt_tbl;
    end
  end

  // start-up capture; later the pins belong to the serial port only
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_sel_lo = sel_lo_ff; // RQ19
    case (state_ff)
      TPS_WAIT: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == 4'(`TPS_CAPT_CYC - 1)) begin
          nxt_sel_lo = {sclk_s, serial_data_pin_s}; // RQ1
          nxt_state  = TPS_RUN;
        end
      end
      default: nxt_state = TPS_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff  <= TPS_WAIT;
      cnt_ff    <= 4'h0;
      sel_lo_ff <= 2'h0;
    end else if (ce) begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      sel_lo_ff <= nxt_sel_lo;
    end
  end

  assign run    = (state_ff == TPS_RUN);
  assign oe_low = ~oe_s;
  assign pd     = oe_low & ctrl_ff[`TPS_F_SDEN];   // RQ2 RQ18
  assign susp   = ctrl_ff[`TPS_F_S2SUSP] & ~s2_s;  // RQ17
  assign idx    = {s2_s & ~ctrl_ff[`TPS_F_S2SUSP], sel_lo_ff}; // RQ4 RQ8
  assign row    = tbl_ff[idx]; // RQ9

  // active pll1 setting and shared a/b divider choice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_ff  <= 3'h0;
      p1_ff   <= 11'h000;
      q1_ff   <= 8'h00;
      dsel_ff <= 1'b0;
      pd_ff   <= 1'b0;
      cap_ff  <= 6'h00;
    end else if (ce) begin
      if (run) begin
        idx_ff  <= idx;
        p1_ff   <= row[`TPS_F_P +: 11]; // RQ9
        q1_ff   <= row[`TPS_F_Q +: 8];
        dsel_ff <= row[`TPS_F_DSEL];    // RQ10
      end
      pd_ff  <= pd; // RQ18
      // a bypassed input sees no load at all
      cap_ff <= ctrl_ff[`TPS_F_BYP] ? 6'h00 : ctrl_ff[`TPS_F_CAP +: 6]; // RQ13 RQ14
    end
  end

  always_comb begin
    pp[0] = p1_ff;
    pq[0] = q1_ff;
    pp[1] = pll2_ff[`TPS_F_P +: 11];
    pq[1] = pll2_ff[`TPS_F_Q +: 8];
    pp[2] = pll3_ff[`TPS_F_P +: 11];
    pq[2] = pll3_ff[`TPS_F_Q +: 8];
    for (int k = 0; k < 3; k++) begin
      prun[k] = run & ~pd & route_ff[`TPS_F_PLLEN + k] & ~(susp & susp_ff[`TPS_F_MSK_PLL + k]); // RQ17
    end
  end

  // each pll is a rate generator: ticks at p/q of the reference,
  // clipped to one tick per cycle when p is not below q
  for (genvar k = 0; k < 3; k++) begin : g_pll
    logic [11:0] sum;
    logic [7:0]  nxt_acc;
    logic        nxt_tk;
    always_comb begin
      sum     = {4'h0, acc_ff[k]} + {1'b0, pp[k]};
      nxt_acc = 8'h00;
      nxt_tk  = 1'b0;
      if (prun[k] && pq[k] != 8'h00) begin
        if ({1'b0, pp[k]} >= {4'h0, pq[k]}) begin
          nxt_tk = 1'b1;
        end else if (sum >= {4'h0, pq[k]}) begin
          nxt_tk  = 1'b1;
          nxt_acc = 8'(sum - {4'h0, pq[k]}); // RQ5
        end else begin
          nxt_acc = 8'(sum);
        end
      end
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        acc_ff[k]   <= 8'h00;
        ptick_ff[k] <= 1'b0;
      end else if (ce) begin
        acc_ff[k]   <= nxt_acc;
        ptick_ff[k] <= nxt_tk;
      end
    end
  end

  // cross point sources: 0 reference, 1..3 plls
  assign stick = {ptick_ff, run & ~pd};

  always_comb begin
    dv[0] = dsel_ff ? diva_ff[`TPS_F_DIV1 +: 7] : diva_ff[6:0]; // RQ10
    dv[1] = dsel_ff ? divb_ff[`TPS_F_DIV1 +: 7] : divb_ff[6:0]; // RQ10
    dv[2] = divcd_ff[6:0];
    dv[3] = divcd_ff[`TPS_F_DIV1 +: 7];
    case (route_ff[`TPS_F_EDIV +: 2])
      2'h1:    dv[4] = 7'h04; // RQ6
      2'h2:    dv[4] = 7'h02;
      2'h3:    dv[4] = 7'h03;
      default: dv[4] = 7'h00;
    endcase
    for (int j = 0; j < 4; j++) begin
      srcsel[j] = route_ff[2*j +: 2];
    end
    srcsel[4] = 2'h1; // RQ6
    for (int j = 0; j < 5; j++) begin
      o_off[j] = (dv[j] == 7'h00) | ~run | oe_low | (susp & susp_ff[j]); // RQ2 RQ3 RQ16
    end
  end

  // a tick is one source edge, so toggling every n ticks divides by n;
  // a new divisor is loaded only at a toggle, which keeps changes glitch free
  for (genvar j = 0; j < 5; j++) begin : g_div
    tps_div_t nxt_cur, nxt_dcnt;
    logic     nxt_o;
    always_comb begin
      nxt_cur  = cur_ff[j];
      nxt_dcnt = dcnt_ff[j];
      nxt_o    = clk_ff[j];
      if (dv[j] == 7'h00) begin
        nxt_cur  = 7'h00; // RQ16
        nxt_dcnt = 7'h00;
        nxt_o    = 1'b0;
      end else if (stick[srcsel[j]]) begin
        if (cur_ff[j] == 7'h00 || dcnt_ff[j] >= cur_ff[j] - 7'h01) begin
          nxt_dcnt = 7'h00;
          nxt_o    = ~clk_ff[j];
          nxt_cur  = dv[j]; // RQ11
        end else begin
          nxt_dcnt = dcnt_ff[j] + 7'h01;
        end
      end
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cur_ff[j]  <= 7'h00;
        dcnt_ff[j] <= 7'h00;
        clk_ff[j]  <= 1'b0;
        oen_ff[j]  <= 1'b1;
      end else if (ce) begin
        cur_ff[j]  <= nxt_cur;
        dcnt_ff[j] <= nxt_dcnt;
        clk_ff[j]  <= nxt_o;
        oen_ff[j]  <= o_off[j];
      end
    end
  end

  // reference buffer stops with the oscillator in shutdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_ff     <= 1'b0;
      ref_oen_ff <= 1'b1;
    end else if (ce) begin
      ref_ff     <= (run & ~pd) ? ~ref_ff : ref_ff; // RQ15
      ref_oen_ff <= ~run | oe_low | (susp & susp_ff[`TPS_F_MSK_REF]);
    end
  end

  assign rdata          = rdata_ff;
  assign {output_e, output_d, output_c, output_b, output_a} = clk_ff;
  assign {output_e_oe_n, output_d_oe_n, output_c_oe_n, output_b_oe_n, output_a_oe_n} = oen_ff;
  assign ref_out        = ref_ff;
  assign ref_out_oe_n   = ref_oen_ff;
  assign chip_powerdown = pd_ff;
  assign pll1_p         = p1_ff;
  assign pll1_q         = q1_ff;
  assign xtal_drive     = ctrl_ff[`TPS_F_DRV +: 2]; // RQ12
  assign xtal_cap       = cap_ff;
  assign xtal_bypass    = ctrl_ff[`TPS_F_BYP]; // RQ14

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_capture_pins: assert property (ce && !run && cnt_ff == 4'(`TPS_CAPT_CYC - 1) // RQ1
    |=> sel_lo_ff == $past({sclk_s, serial_data_pin_s}))
    else $error("select bits not captured from pins");
  a_capture_hold: assert property (run && $past(run) |-> $stable(sel_lo_ff)) // RQ19
    else $error("captured select bits changed");
  a_oe_tristate: assert property (ce && oe_low |=> (&oen_ff) && ref_oen_ff) // RQ2
    else $error("outputs driven while shutdown pin low");
  a_pd_only_en: assert property (ce |=> chip_powerdown == $past(oe_low && ctrl_ff[`TPS_F_SDEN])) // RQ18
    else $error("power down does not follow enable and pin");
  a_oe_no_pd: assert property (ce && oe_low && !ctrl_ff[`TPS_F_SDEN] |=> !chip_powerdown) // RQ3
    else $error("chip powered down in tristate-only mode");
  a_index_bit2: assert property (ce && run |=> idx_ff[2] == $past(s2_s && !ctrl_ff[`TPS_F_S2SUSP])) // RQ4
    else $error("index bit two wrong");
  a_row_pll1: assert property (ce && run |=> pll1_p == $past(row[`TPS_F_P +: 11]) && dsel_ff == $past(row[24])) // RQ9
    else $error("pll1 setting not taken from selected row");
  a_div_glitch: assert property ($changed(cur_ff[0]) |-> dcnt_ff[0] == 7'h00) // RQ11
    else $error("output a divisor changed mid period");
  a_div_zero: assert property (ce && dv[1] == 7'h00 |=> output_b_oe_n && !output_b) // RQ16
    else $error("zero divider did not stop output b");
  a_pll_suspend: assert property (ce && susp && susp_ff[`TPS_F_MSK_PLL] |=> !ptick_ff[0]) // RQ17
    else $error("suspended pll1 still running");
  a_e_divide: assert property (ce && route_ff[`TPS_F_EDIV +: 2] == 2'h2 && ptick_ff[0] // RQ6
    |=> cur_ff[4] == 7'h02 || dcnt_ff[4] != 7'h00)
    else $error("output e divisor wrong");

  c_capture:  cover property (run && !$past(run));
  c_suspend:  cover property (susp && !oen_ff[0]);
  c_shutdown: cover property (chip_powerdown);
  c_dsel_sw:  cover property ($changed(dsel_ff) && run);

endmodule

// ### tps_map.svh
// register offsets, field positions, reset values and timing counts
// assumes word addressing on a 6-bit register port with 32-bit data
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH

`define TPS_A_CTRL    6'h00
`define TPS_A_ROUTE   6'h01
`define TPS_A_DIVA    6'h02
`define TPS_A_DIVB    6'h03
`define TPS_A_DIVCD   6'h04
`define TPS_A_SUSP    6'h05
`define TPS_A_PLL2    6'h06
`define TPS_A_PLL3    6'h07
`define TPS_A_TBL     3'h1
`define TPS_A_STAT    6'h10

`define TPS_F_SDEN    0
`define TPS_F_S2SUSP  1
`define TPS_F_BYP     2
`define TPS_F_DRV     3
`define TPS_F_CAP     5
`define TPS_F_EDIV    8
`define TPS_F_PLLEN   10
`define TPS_F_DIV1    8
`define TPS_F_Q       0
`define TPS_F_P       8
`define TPS_F_DSEL    24
`define TPS_F_MSK_E   4
`define TPS_F_MSK_REF 5
`define TPS_F_MSK_PLL 6

`define TPS_CTRL_RST  32'h0000_0001
`define TPS_ROUTE_RST 32'h0000_1c00

`define TPS_CLK_NS    10
`define TPS_CAPT_NS   50
`define TPS_CAPT_CYC  ((`TPS_CAPT_NS + `TPS_CLK_NS - 1) / `TPS_CLK_NS)

`endif

// ### tps_pkg.sv
// types shared by the three-pll frequency select control
// assumes tps_map.svh holds all numeric constants
package tps_pkg;
  typedef enum logic {TPS_WAIT, TPS_RUN} tps_state_t;
  typedef logic [10:0] tps_p_t;
  typedef logic [7:0]  tps_q_t;
  typedef logic [6:0]  tps_div_t;
  typedef logic [1:0]  tps_src_t;
endpackage

// ### tps_load.sv
// clock load model: counts level changes and the shortest run seen at one pin
// assumes the reference clock samples fast enough for the divided outputs
`timescale 1ns/1ps
module tps_load (
  input  wire logic        clk,      // reference clock
  input  wire logic        clr,      // restart both measurements
  input  wire logic        sig,      // output level when driven
  input  wire logic        oe_n,     // low while the output drives
  output logic      [15:0] edges,    // changes seen while driven
  output logic      [7:0]  shortest  // shortest level run seen
);
  logic       line;
  logic       last_ff;
  logic [7:0] run_ff;
  // a released pin floats, so the load sees the opposite of the last driven level
  assign line = oe_n ? ~last_ff : sig;
  always_ff @(posedge clk) begin
    if (!oe_n) last_ff <= line;
    if (clr) begin
      edges    <= 16'h0000;
      shortest <= 8'hff;
      run_ff   <= 8'hff;
    end else if (!oe_n && line !== last_ff) begin
      edges  <= edges + 16'h0001;
      run_ff <= 8'h01;
      if (run_ff < shortest) shortest <= run_ff;
    end else if (run_ff != 8'hff) begin
      run_ff <= run_ff + 8'h01;
    end
  end
endmodule

// ### tb_three_pll_frequency_select_control.sv
// self-checking bench for the three-pll frequency select control
// assumes clk is also the reference and tps_load stands for the clock loads
`timescale 1ns/1ps
`include "tps_map.svh"
module tb_three_pll_frequency_select_control
  import tps_pkg::*;
;
  logic        clk, rst, ce, wr, rd, sd, sc, b2, oen, clr;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, seed, d, v;
  logic        oa, oa_n, ob, ob_n, oc, oc_n, od, od_n, oe, oe_n_e, rf, rf_n, pdn, byp;
  logic [10:0] p1p;
  logic [7:0]  p1q, sa;
  logic [1:0]  drv;
  logic [5:0]  cap;
  logic [15:0] na, nb, nd, ne, nr;
  logic [10:0] rp [8];
  logic [7:0]  rq [8];
  logic [15:0] ec [4];
  logic [2:0]  idx;
  int          err_count, checks_done, i;

  tps_clkgen i_tps_clkgen (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .serial_data_pin(sd), .serial_clock_pin(sc), .live_select_bit_two(b2),
    .oe_shutdown_n(oen), .output_a(oa), .output_a_oe_n(oa_n), .output_b(ob), .output_b_oe_n(ob_n),
    .output_c(oc), .output_c_oe_n(oc_n), .output_d(od), .output_d_oe_n(od_n), .output_e(oe),
    .output_e_oe_n(oe_n_e), .ref_out(rf), .ref_out_oe_n(rf_n), .chip_powerdown(pdn), .pll1_p(p1p),
    .pll1_q(p1q), .xtal_drive(drv), .xtal_cap(cap), .xtal_bypass(byp));
  tps_load i_tps_load_a (.clk(clk), .clr(clr), .sig(oa), .oe_n(oa_n), .edges(na), .shortest(sa));
  tps_load i_tps_load_b (.clk(clk), .clr(clr), .sig(ob), .oe_n(ob_n), .edges(nb), .shortest());
  tps_load i_tps_load_d (.clk(clk), .clr(clr), .sig(od), .oe_n(od_n), .edges(nd), .shortest());
  tps_load i_tps_load_e (.clk(clk), .clr(clr), .sig(oe), .oe_n(oe_n_e), .edges(ne), .shortest());
  tps_load i_tps_load_r (.clk(clk), .clr(clr), .sig(rf), .oe_n(rf_n), .edges(nr), .shortest());

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  // divided clocks are counted loosely: the window edges cut a period
  task automatic near(input string nm, input int exp, input logic [15:0] got);
    checks_done++;
    if ($isunknown(got) || int'(got) < exp - 2 || int'(got) > exp + 2) begin
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] x);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [31:0] x);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 x = rdata;
  endtask
  task automatic cnt(input int w);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (w) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 6'h00; wdata = 32'h0;
    sd = 1'b1; sc = 1'b0; b2 = 1'b0; oen = 1'b1; clr = 1'b0; seed = 32'h0001_3d6e;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`TPS_A_CTRL, d);
    chk("ctrl reset", `TPS_CTRL_RST, d);
    rd_reg(`TPS_A_ROUTE, d);
    chk("route reset", `TPS_ROUTE_RST, d);
    rd_reg(6'h3f, d);
    chk("unmapped read", 32'h0, d);
    d = 32'h0;
    for (i = 0; i < 20 && d[6] !== 1'b1; i++) rd_reg(`TPS_A_STAT, d);
    chk("run", 32'h1, {31'h0, d[6]});
    chk("captured bits", 32'h1, {30'h0, d[5:4]});
    // serial pins now carry traffic; the captured index must not follow them
    @(posedge clk);
    sd <= 1'b0;
    sc <= 1'b1;
    repeat (8) @(posedge clk);
    rd_reg(`TPS_A_STAT, d);
    chk("captured held", 32'h1, {30'h0, d[5:4]});
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      rp[i] = seed[10:0] | 11'h001;
      rq[i] = seed[18:11] | 8'h01;
      wr_reg(6'h08 + 6'(i), {7'h0, i[2], 5'h0, rp[i], rq[i]});
    end
    wr_reg(`TPS_A_DIVA, 32'h0000_0503);
    wr_reg(`TPS_A_DIVB, 32'h0000_0402);
    wr_reg(`TPS_A_DIVCD, 32'h0000_0600);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      b2 <= i[0];
      repeat (5) @(posedge clk);
      idx = {i[0], 2'b01};
      #1 chk("pll1 p", {21'h0, rp[idx]}, {21'h0, p1p});
      chk("pll1 q", {24'h0, rq[idx]}, {24'h0, p1q});
      rd_reg(`TPS_A_STAT, d);
      chk("index", {28'h0, i[0], idx}, {28'h0, d[3:0]});
      cnt(120);
      near("output a", i ? 24 : 40, na);
      near("output b", i ? 30 : 60, nb);
      near("ref out", 120, nr);
      near("output d", 20, nd);
      chk("output c off", 32'h2, {30'h0, oc_n, oc});
      chk("output d driven", 32'h0, {31'h0, od_n});
    end
    cnt(30);
    @(posedge clk);
    b2 <= 1'b0;
    repeat (40) @(posedge clk);
    #1 chk("a glitch free", 32'h1, {31'h0, sa >= 8'h03});
    for (i = 0; i < 4; i++) begin
      wr_reg(`TPS_A_ROUTE, 32'h0000_1c00 | (i << 8));
      cnt(120);
      ec[i] = ne;
    end
    chk("e off", 32'h0, {16'h0, ec[0]});
    chk("e order", 32'h1, {31'h0, ec[2] > ec[3] && ec[3] > ec[1] && ec[1] > 16'h0});
    // pll2 at half and pll3 at a quarter of the reference feed outputs a and b
    wr_reg(`TPS_A_PLL2, 32'h0000_0102);
    wr_reg(`TPS_A_PLL3, 32'h0000_0104);
    wr_reg(`TPS_A_ROUTE, 32'h0000_1f0e);
    cnt(120);
    near("a from pll2", 20, na);
    near("b from pll3", 15, nb);
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = {21'h0, seed[5:0], seed[7:6], i[0], 2'b01};
      wr_reg(`TPS_A_CTRL, v);
      rd_reg(`TPS_A_CTRL, d);
      chk("ctrl readback", v, d);
      chk("drive", {30'h0, seed[7:6]}, {30'h0, drv});
      chk("cap", {26'h0, i[0] ? 6'h00 : seed[5:0]}, {26'h0, cap});
      chk("bypass", {31'h0, i[0]}, {31'h0, byp});
    end
    wr_reg(`TPS_A_CTRL, 32'h1);
    oen <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("shutdown oe", 32'h3f, {26'h0, oa_n, ob_n, oc_n, od_n, oe_n_e, rf_n});
    chk("powerdown", 32'h1, {31'h0, pdn});
    @(posedge clk);
    oen <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("wake", 32'h0, {30'h0, pdn, oa_n});
    wr_reg(`TPS_A_CTRL, 32'h0);
    oen <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("tristate only", 32'h3f, {25'h0, pdn, oa_n, ob_n, oc_n, od_n, oe_n_e, rf_n});
    @(posedge clk);
    oen <= 1'b1;
    wr_reg(`TPS_A_CTRL, 32'h3);
    // suspend stops output a and pll1, so output e must fall silent
    wr_reg(`TPS_A_SUSP, 32'h41);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      b2 <= i[0];
      repeat (6) @(posedge clk);
      #1 chk("suspend a b", {30'h0, ~i[0], 1'b0}, {30'h0, oa_n, ob_n});
      chk("suspend index", {21'h0, rp[1]}, {21'h0, p1p});
      cnt(60);
      near("suspend e", i ? 20 : 0, ne);
    end
    close_out();
  end
endmodule
